// file: logic/bpl_pkg.sv
/*
  Constants and carrier types for the banked I/O window and packet buffer layout.
  Assumes a single 50 MHz host-interface clock and synchronous active-low reset.
*/
package bpl_pkg;

  // host window layout
  localparam logic [3:0] BSR_OFFSET = 4'hE;
  localparam logic [3:0] SHARED_DWORD_OFFSET = 4'hC;
  localparam logic [3:0] TCR_OFFSET = 4'h0;
  localparam logic [3:0] HASH_TABLE_OFFSET = 4'h0;
  localparam logic [3:0] REVISION_OFFSET = 4'hA;
  localparam logic [2:0] BANK_TCR = 3'h0;
  localparam logic [2:0] BANK_HASH = 3'h3;
  localparam logic [2:0] BANK_EXTERNAL = 3'h7;
  localparam logic [2:0] BANK_SEL_RESET = 3'h0;
  localparam logic [15:0] TCR_RESET = 16'h0000;
  localparam int TCR_SUPPRESS_FCS_BIT = 8;
  localparam logic [63:0] HASH_TABLE_RESET = 64'h0000_0000_0000_0000;
  localparam logic [11:0] IO_BASE_RESET = 12'h000;

  // packet structure in buffer memory
  localparam logic [15:0] PKT_HEADER_BYTES = 16'h0004;
  localparam logic [15:0] PKT_OVERHEAD_BYTES = 16'h0006;
  localparam logic [10:0] DATA_AREA_MAX = 11'h7FB;
  localparam int TX_CTRL_ODD_BIT = 5;
  localparam int TX_CTRL_FCS_BIT = 4;
  localparam logic [7:0] RX_CTRL_BASE = 8'h40;
  localparam int RX_CTRL_ODD_BIT = 5;

  // receive frame status word fields
  localparam int RXS_ALIGN_BIT = 15;
  localparam int RXS_BCAST_BIT = 14;
  localparam int RXS_FCS_BIT = 13;
  localparam int RXS_ODD_BIT = 12;
  localparam int RXS_LONG_BIT = 11;
  localparam int RXS_SHORT_BIT = 10;
  localparam int RXS_GROUP_BIT = 0;
  localparam int HASH_LSB = 26;
  localparam logic [15:0] FRAME_MAX_BYTES = 16'h05EE;
  localparam logic [15:0] FRAME_MIN_BYTES = 16'h0040;

  typedef struct packed {
    logic valid;
    logic rd;
    logic wr;
    logic [15:2] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bpl_host_req_type;

  typedef struct packed {
    logic done;
    logic [15:0] data_bytes;
    logic fcs_ok;
    logic rx_er_seen;
    logic mii_mode;
    logic nibble_odd;
    logic [2:0] bit_residual;
    logic [31:0] dest_crc;
    logic dest_group;
    logic dest_bcast;
  } bpl_rx_report_type;

  typedef struct packed {
    logic valid;
    logic [15:0] status;
    logic [15:0] count;
    logic [7:0] ctrl;
    logic accept;
  } bpl_rx_result_type;

endpackage : bpl_pkg

// file: logic/bpl_rx_status.sv
/*
  Builds the receive frame status word, byte count and control byte.
  Assumes the receive engine reports one finished frame per done pulse.
*/
`timescale 1ns/1ps
module bpl_rx_status (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire bpl_pkg::bpl_rx_report_type report_in,
  input wire logic [63:0] hash_table_in,
  output bpl_pkg::bpl_rx_result_type result_out
);

  bpl_pkg::bpl_rx_result_type result_ff;
  bpl_pkg::bpl_rx_result_type nxt_result;
  wire [5:0] hash = report_in.dest_crc[bpl_pkg::HASH_LSB +: 6]; // [RULE15]
  wire hash_hit = hash_table_in[{hash[5:3], hash[2:0]}]; // [RULE15]
  wire group_frame = report_in.dest_group & hash_hit; // [RULE16]
  wire fcs_fault = ~report_in.fcs_ok | report_in.rx_er_seen; // [RULE13]
  wire misaligned = report_in.mii_mode ? report_in.nibble_odd : (report_in.bit_residual != 3'h0);
  wire alignment_fault = fcs_fault & misaligned; // [RULE12]
  wire odd_length_frame = report_in.data_bytes[0];
  wire oversize_frame = report_in.data_bytes > bpl_pkg::FRAME_MAX_BYTES; // [RULE14]
  wire undersize_frame = report_in.data_bytes < bpl_pkg::FRAME_MIN_BYTES; // [RULE14]
  // odd frames share the last word with the control byte, even ones pad a byte
  wire [15:0] count_raw = report_in.data_bytes + (odd_length_frame ? 16'h0005 : bpl_pkg::PKT_OVERHEAD_BYTES);

  always_comb
  begin
    nxt_result = '0;
    nxt_result.valid = report_in.done;
    nxt_result.status[bpl_pkg::RXS_ALIGN_BIT] = alignment_fault; // [RULE12]
    nxt_result.status[bpl_pkg::RXS_BCAST_BIT] = report_in.dest_bcast;
    nxt_result.status[bpl_pkg::RXS_FCS_BIT] = fcs_fault; // [RULE13]
    nxt_result.status[bpl_pkg::RXS_ODD_BIT] = odd_length_frame; // [RULE3]
    nxt_result.status[bpl_pkg::RXS_LONG_BIT] = oversize_frame;
    nxt_result.status[bpl_pkg::RXS_SHORT_BIT] = undersize_frame;
    nxt_result.status[5:0] = hash; // [RULE15]
    nxt_result.count = {count_raw[15:1], 1'b0}; // [RULE2] [RULE3]
    nxt_result.ctrl = bpl_pkg::RX_CTRL_BASE; // [RULE10]
    nxt_result.ctrl[bpl_pkg::RX_CTRL_ODD_BIT] = odd_length_frame; // [RULE10]
    nxt_result.accept = group_frame; // [RULE16]
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      result_ff <= '0;
    else
      result_ff <= nxt_result; // [RULE11]
  end

  assign result_out = result_ff;

endmodule : bpl_rx_status

// file: logic/bpl_io_window.sv
/*
  Banked 16-byte host I/O window with bank select, external register select,
  transmit descriptor decode and receive status generation for the packet buffer.
  Assumes host requests are synchronous to CLK_IN and the buffer memory is
  written and read by the access engine outside this block.
*/
// Behaviour
// (RULE1) each buffered packet is status word, count word, then frame data
// (RULE2) byte count halved equals words of status, count, data and control byte
// (RULE3) receive count always even; odd-frame flag says last low byte is valid
// (RULE4) transmit byte count least bit read as zero
// (RULE5) data area starts at byte 4, at most 2043 bytes
// (RULE6) host supplies all transmit bytes; no station address inserted
// (RULE7) length/type field passes through as plain payload
// (RULE8) byte before transmit control byte sent only when odd flag set
// (RULE9) per-packet append flag adds fcs, honoured only when global suppress set
// (RULE10) receive control byte: bit7 zero, bit6 one, bit5 odd, rest zero
// (RULE11) receive status stored as first word in memory, never a register
// (RULE12) alignment fault only with fcs fault, by nibble or bit residue
// (RULE13) fcs fault on bad check sequence or any rx error during frame
// (RULE14) oversize above 1518 bytes, undersize below 64 bytes
// (RULE15) six-bit hash from top crc bits; 5..3 byte, 2..0 bit
// (RULE16) group frame hitting set table bit is accepted and flagged; code sets accept only, status bit 0 carries hash bit 0
// (RULE17) io base from three select inputs plus eeprom config
// (RULE18) sixteen byte window, banked, last word selects bank
// (RULE19) offset hits even byte or word, odd byte at offset plus one
// (RULE20) bank select always reachable; three low bits bank, upper byte signature
// (RULE21) doubleword write at C updates bank select, not bytes C and D
// (RULE22) bank 7 with A3 low asserts external register select
// (RULE23) host checks revision before touching bank 7
// (RULE24) suppress bit set means no fcs unless packet flag asks
// (RULE25) host selects bank before accessing offsets 0 through D
`timescale 1ns/1ps
module bpl_io_window #(
  parameter logic [7:0] SIGNATURE = 8'h5A, // arbitrary value
  parameter logic [15:0] REVISION = 16'h0001 // arbitrary value
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire bpl_pkg::bpl_host_req_type HOST_REQ_IN,
  input wire logic [2:0] IO_BASE_SELECT_IN,
  input wire logic [8:0] EEPROM_BASE_IN,
  input wire logic EEPROM_LOAD_IN,
  input wire logic TX_DESC_VALID_IN,
  input wire logic [15:0] TX_COUNT_IN,
  input wire logic [7:0] TX_CTRL_IN,
  input wire bpl_pkg::bpl_rx_report_type RX_REPORT_IN,
  output logic [31:0] RDATA_OUT,
  output logic ACK_OUT,
  output logic EXT_REG_SELECT_N_OUT,
  output logic [2:0] BANK_OUT,
  output logic [10:0] TX_DATA_LEN_OUT,
  output logic TX_APPEND_FCS_OUT,
  output logic TX_LEN_ERR_OUT,
  output logic TX_DESC_DONE_OUT,
  output bpl_pkg::bpl_rx_result_type RX_RESULT_OUT
);

  logic [2:0] bank_sel_ff;
  logic [15:0] tx_control_reg_ff;
  logic [63:0] group_hash_table_ff;
  logic [11:0] io_base_ff;
  logic [31:0] rdata_ff;
  logic ack_ff;
  logic ext_sel_n_ff;
  logic [10:0] tx_len_ff;
  logic tx_fcs_ff;
  logic tx_err_ff;
  logic tx_done_ff;
  logic [2:0] nxt_bank_sel;
  logic [15:0] nxt_tx_control;
  logic [63:0] nxt_hash_table;

  // address decode: window of 16 bytes at io base
  wire hit = HOST_REQ_IN.valid && (HOST_REQ_IN.addr[15:4] == io_base_ff); // [RULE18]
  wire do_wr = hit & HOST_REQ_IN.wr;
  wire do_rd = hit & HOST_REQ_IN.rd;
  wire full_dword = HOST_REQ_IN.be == 4'hF;
  wire shared_dword = HOST_REQ_IN.addr[3:2] == bpl_pkg::SHARED_DWORD_OFFSET[3:2];
  wire bank7 = bank_sel_ff == bpl_pkg::BANK_EXTERNAL;
  wire ext_sel = hit && bank7 && !HOST_REQ_IN.addr[3]; // [RULE22]
  wire [2:0] bank_sel_bit = bank_sel_ff;
  wire suppress_fcs = tx_control_reg_ff[bpl_pkg::TCR_SUPPRESS_FCS_BIT];

  // per byte lane offsets and strobes
  wire [3:0] lane_off [4];
  wire [3:0] lane_we;
  wire [7:0] lane_rd [4];

  // registers come in as arguments so the continuous assign re-evaluates when they change
  function automatic logic [7:0] read_byte(input logic [3:0] off, input logic [2:0] bank, input logic [15:0] tx_control_reg,
    input logic [63:0] tbl);
    logic [7:0] val;
    val = 8'h00;
    if (off == bpl_pkg::BSR_OFFSET)
      val = {5'h00, bank}; // [RULE20]
    else if (off == bpl_pkg::BSR_OFFSET + 4'h1)
      val = SIGNATURE; // [RULE20]
    else if (bank == bpl_pkg::BANK_TCR && off[3:1] == bpl_pkg::TCR_OFFSET[3:1])
      val = off[0] ? tx_control_reg[15:8] : tx_control_reg[7:0]; // [RULE19]
    else if (bank == bpl_pkg::BANK_HASH && off[3] == bpl_pkg::HASH_TABLE_OFFSET[3])
      val = tbl[{off[2:0], 3'h0} +: 8];
    else if (bank == bpl_pkg::BANK_HASH && off[3:1] == bpl_pkg::REVISION_OFFSET[3:1])
      val = off[0] ? REVISION[15:8] : REVISION[7:0]; // [RULE23]
    return val;
  endfunction : read_byte

  genvar k;
  generate
    for (k = 0; k < 4; k++)
    begin : g_lane
      assign lane_off[k] = {HOST_REQ_IN.addr[3:2], 2'(k)}; // [RULE19]
      // a full doubleword at C reaches bank select only
      assign lane_we[k] = do_wr && HOST_REQ_IN.be[k] && !(full_dword && shared_dword && k < 2); // [RULE21]
      assign lane_rd[k] = HOST_REQ_IN.be[k] ? read_byte(lane_off[k], bank_sel_ff, tx_control_reg_ff,
        group_hash_table_ff) : 8'h00;
    end
  endgenerate

  always_comb
  begin
    nxt_bank_sel = bank_sel_ff;
    nxt_tx_control = tx_control_reg_ff;
    nxt_hash_table = group_hash_table_ff;
    for (int i = 0; i < 4; i++)
    begin
      if (lane_we[i])
      begin
        if (lane_off[i] == bpl_pkg::BSR_OFFSET)
          nxt_bank_sel = HOST_REQ_IN.wdata[8 * i +: 3]; // [RULE20] [RULE25]
        else if (bank_sel_ff == bpl_pkg::BANK_TCR && lane_off[i][3:1] == bpl_pkg::TCR_OFFSET[3:1])
        begin
          if (lane_off[i][0])
            nxt_tx_control[15:8] = HOST_REQ_IN.wdata[8 * i +: 8];
          else
            nxt_tx_control[7:0] = HOST_REQ_IN.wdata[8 * i +: 8];
        end
        else if (bank_sel_ff == bpl_pkg::BANK_HASH && lane_off[i][3] == bpl_pkg::HASH_TABLE_OFFSET[3])
          nxt_hash_table[{lane_off[i][2:0], 3'h0} +: 8] = HOST_REQ_IN.wdata[8 * i +: 8];
      end
    end
  end

  // transmit descriptor decode; frame bytes themselves are never examined
  wire [15:0] tx_count_even = {TX_COUNT_IN[15:1], 1'b0}; // [RULE4]
  wire tx_odd = TX_CTRL_IN[bpl_pkg::TX_CTRL_ODD_BIT];
  wire tx_short = tx_count_even < bpl_pkg::PKT_OVERHEAD_BYTES;
  wire [15:0] tx_data_full = tx_count_even - bpl_pkg::PKT_OVERHEAD_BYTES + {15'h0000, tx_odd}; // [RULE8] [RULE2]
  wire tx_too_big = tx_data_full > {5'h00, bpl_pkg::DATA_AREA_MAX}; // [RULE5]
  wire [10:0] tx_data_len = (tx_short || tx_too_big) ? 11'h000 : tx_data_full[10:0]; // [RULE1] [RULE6] [RULE7]
  wire tx_fcs = !suppress_fcs || TX_CTRL_IN[bpl_pkg::TX_CTRL_FCS_BIT]; // [RULE9] [RULE24]

  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      bank_sel_ff <= bpl_pkg::BANK_SEL_RESET;
      tx_control_reg_ff <= bpl_pkg::TCR_RESET;
      group_hash_table_ff <= bpl_pkg::HASH_TABLE_RESET;
    end
    else
    begin
      bank_sel_ff <= nxt_bank_sel;
      tx_control_reg_ff <= nxt_tx_control;
      group_hash_table_ff <= nxt_hash_table;
    end
  end

  // base latched from straps and eeprom only when the eeprom load completes
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
      io_base_ff <= bpl_pkg::IO_BASE_RESET;
    else if (EEPROM_LOAD_IN)
      io_base_ff <= {EEPROM_BASE_IN, IO_BASE_SELECT_IN}; // [RULE17]
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      rdata_ff <= 32'h0000_0000;
      ack_ff <= 1'b0;
      ext_sel_n_ff <= 1'b1;
    end
    else
    begin
      rdata_ff <= do_rd ? {lane_rd[3], lane_rd[2], lane_rd[1], lane_rd[0]} : 32'h0000_0000;
      ack_ff <= do_rd | do_wr;
      ext_sel_n_ff <= !ext_sel; // [RULE22]
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      tx_len_ff <= 11'h000;
      tx_fcs_ff <= 1'b0;
      tx_err_ff <= 1'b0;
      tx_done_ff <= 1'b0;
    end
    else
    begin
      tx_done_ff <= TX_DESC_VALID_IN;
      if (TX_DESC_VALID_IN)
      begin
        tx_len_ff <= tx_data_len; // [RULE8]
        tx_fcs_ff <= tx_fcs; // [RULE9]
        tx_err_ff <= tx_short || tx_too_big; // [RULE5]
      end
    end
  end

  bpl_rx_status u_rx_status (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .report_in(RX_REPORT_IN),
    .hash_table_in(group_hash_table_ff),
    .result_out(RX_RESULT_OUT)
  );

  assign RDATA_OUT = rdata_ff;
  assign ACK_OUT = ack_ff;
  assign EXT_REG_SELECT_N_OUT = ext_sel_n_ff;
  assign BANK_OUT = bank_sel_bit;
  assign TX_DATA_LEN_OUT = tx_len_ff;
  assign TX_APPEND_FCS_OUT = tx_fcs_ff;
  assign TX_LEN_ERR_OUT = tx_err_ff;
  assign TX_DESC_DONE_OUT = tx_done_ff;

endmodule : bpl_io_window

// file: testbench/bpl_io_window_sva.sv
/*
  Port checker for the banked host window, descriptor and receive status paths.
  Assumes one clock and a synchronous active-low reset; tracks base and suppress bit itself.
*/
`timescale 1ns/1ps
module bpl_io_window_sva #(
  parameter logic [7:0] SIGNATURE = 8'h5A
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire bpl_pkg::bpl_host_req_type HOST_REQ_IN,
  input wire logic [2:0] IO_BASE_SELECT_IN,
  input wire logic [8:0] EEPROM_BASE_IN,
  input wire logic EEPROM_LOAD_IN,
  input wire logic TX_DESC_VALID_IN,
  input wire logic [7:0] TX_CTRL_IN,
  input wire bpl_pkg::bpl_rx_report_type RX_REPORT_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic ACK_OUT,
  input wire logic EXT_REG_SELECT_N_OUT,
  input wire logic [2:0] BANK_OUT,
  input wire logic TX_APPEND_FCS_OUT,
  input wire logic TX_DESC_DONE_OUT,
  input wire bpl_pkg::bpl_rx_result_type RX_RESULT_OUT
);
  logic [11:0] base_ff;
  logic supp_ff;
  wire hit = HOST_REQ_IN.valid && HOST_REQ_IN.addr[15:4] == base_ff;
  wire bsel = HOST_REQ_IN.addr[3:2] == 2'h3;
  wire bank_wr = hit && HOST_REQ_IN.wr && bsel && HOST_REQ_IN.be[2];
  wire ext_hit = hit && BANK_OUT == 3'h7 && !HOST_REQ_IN.addr[3];
  wire tcr_wr = hit && HOST_REQ_IN.wr && BANK_OUT == 3'h0 && HOST_REQ_IN.addr[3:2] == 2'h0 && HOST_REQ_IN.be[1];
  // load and access never overlap in the bench, so base timing need not match exactly
  always_ff @(posedge CLK_IN)
  begin
    base_ff <= !RESETN_IN ? 12'h000 : EEPROM_LOAD_IN ? {EEPROM_BASE_IN, IO_BASE_SELECT_IN} : base_ff;
    supp_ff <= !RESETN_IN ? 1'b0 : tcr_wr ? HOST_REQ_IN.wdata[8] : supp_ff;
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  chk_ack_hit: assert property (hit |=> ACK_OUT) else $error("no ack after window access");
  chk_ack_miss: assert property (!hit |=> !ACK_OUT && RDATA_OUT == 32'h0) else $error("stray ack");
  chk_ext_select: assert property (EXT_REG_SELECT_N_OUT == !$past(ext_hit)) else $error("ext select wrong");
  chk_bank_write: assert property (bank_wr |=> BANK_OUT == $past(HOST_REQ_IN.wdata[18:16]))
    else $error("bank not written");
  chk_bank_hold: assert property (!bank_wr |=> $stable(BANK_OUT)) else $error("bank changed");
  chk_sig_read: assert property (hit && HOST_REQ_IN.rd && bsel && HOST_REQ_IN.be[3] |=>
    RDATA_OUT[31:24] == SIGNATURE) else $error("signature wrong");
  chk_tx_fcs: assert property (TX_DESC_VALID_IN |=> TX_DESC_DONE_OUT &&
    TX_APPEND_FCS_OUT == (!$past(supp_ff) || $past(TX_CTRL_IN[4]))) else $error("fcs append wrong");
  chk_rx_ctrl: assert property (RX_REPORT_IN.done |=> RX_RESULT_OUT.valid && !RX_RESULT_OUT.count[0] &&
    RX_RESULT_OUT.ctrl == {2'h1, $past(RX_REPORT_IN.data_bytes[0]), 5'h00}) else $error("rx ctrl");
  chk_rx_fault: assert property (RX_REPORT_IN.done |=> RX_RESULT_OUT.status[13] ==
    ($past(RX_REPORT_IN.rx_er_seen) || !$past(RX_REPORT_IN.fcs_ok))) else $error("fcs fault");
  chk_align_fault: assert property (RX_RESULT_OUT.status[15] |-> RX_RESULT_OUT.status[13])
    else $error("align without fcs fault");
  chk_rx_hash: assert property (RX_REPORT_IN.done |=>
    RX_RESULT_OUT.status[5:0] == $past(RX_REPORT_IN.dest_crc[31:26])) else $error("hash wrong");
  cover property (ext_hit);
  cover property (bank_wr && HOST_REQ_IN.be == 4'hF);
  cover property (RX_RESULT_OUT.valid && RX_RESULT_OUT.accept);
endmodule : bpl_io_window_sva
bind bpl_io_window bpl_io_window_sva #(.SIGNATURE(SIGNATURE)) u_chk (.*);

// file: testbench/bpl_host_model.sv
/*
  Host cpu model issuing one-cycle accesses into the banked window.
  Assumes the answer comes one cycle after the request is taken.
*/
`timescale 1ns/1ps
module bpl_host_model (
  input wire logic clk_in,
  input wire logic [31:0] rdata_in,
  input wire logic ack_in,
  output bpl_pkg::bpl_host_req_type req_out
);
  initial req_out = '0;
  // released fields are inverted so stale values cannot pass
  task automatic access(input logic wr, input logic [15:2] addr, input logic [3:0] be, input logic [31:0] wd,
    output logic [31:0] rd, output logic ok);
    @(posedge clk_in);
    req_out <= {1'b1, !wr, wr, addr, be, wd};
    @(posedge clk_in);
    req_out <= {3'h0, ~addr, ~be, ~wd};
    @(posedge clk_in);
    rd = rdata_in;
    ok = ack_in;
  endtask : access
endmodule : bpl_host_model

// file: testbench/bpl_io_window_tb.sv
/*
  Self-checking bench for the banked window with random descriptors and receive reports.
  Assumes the host model and checker files are compiled alongside the design.
*/
`timescale 1ns/1ps
module bpl_io_window_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  bpl_pkg::bpl_host_req_type req;
  logic [2:0] ios = 3'h0;
  logic [8:0] eeb = 9'h000;
  logic eel = 1'b0;
  logic txv = 1'b0;
  logic [15:0] txc = 16'h0000;
  logic [7:0] txct = 8'h00;
  bpl_pkg::bpl_rx_report_type rep = '0;
  bpl_pkg::bpl_rx_report_type rr;
  bpl_pkg::bpl_rx_result_type res;
  bpl_pkg::bpl_rx_result_type e;
  logic [31:0] rdata, rd;
  logic ack, extn, fcs, lerr, tdone, acked;
  logic [2:0] bank;
  logic [10:0] tlen;
  logic [63:0] tbl, rnd;
  logic [11:0] base = 12'h000;
  logic [15:0] c;
  logic [7:0] ct;
  integer seed = 32'h8C6379A5;
  int failures = 0;
  int comparisons = 0;
  always #10 clk = ~clk;
  bpl_io_window dut (.CLK_IN(clk), .RESETN_IN(resetn), .HOST_REQ_IN(req), .IO_BASE_SELECT_IN(ios),
    .EEPROM_BASE_IN(eeb), .EEPROM_LOAD_IN(eel), .TX_DESC_VALID_IN(txv), .TX_COUNT_IN(txc),
    .TX_CTRL_IN(txct), .RX_REPORT_IN(rep), .RDATA_OUT(rdata), .ACK_OUT(ack), .EXT_REG_SELECT_N_OUT(extn),
    .BANK_OUT(bank), .TX_DATA_LEN_OUT(tlen), .TX_APPEND_FCS_OUT(fcs), .TX_LEN_ERR_OUT(lerr),
    .TX_DESC_DONE_OUT(tdone), .RX_RESULT_OUT(res));
  bpl_host_model host (.clk_in(clk), .rdata_in(rdata), .ack_in(ack), .req_out(req));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic acc(input logic wr, input logic [3:0] off, input logic [3:0] be, input logic [31:0] wd);
    host.access(wr, {base, off[3:2]}, be, wd, rd, acked);
  endtask : acc
  function automatic logic [13:0] exp_tx(input logic [15:0] cnt, input logic [7:0] ctl, input logic s);
    logic [15:0] d;
    d = (cnt & 16'hFFFE) - 16'h0006 + {15'h0, ctl[5]};
    if ((cnt & 16'hFFFE) < 16'h0006 || d > 16'h07FB)
      return {1'b1, 11'h000, !s || ctl[4], 1'b1};
    return {1'b1, d[10:0], !s || ctl[4], 1'b0};
  endfunction : exp_tx
  function automatic bpl_pkg::bpl_rx_result_type exp_rx(input bpl_pkg::bpl_rx_report_type r);
    bpl_pkg::bpl_rx_result_type x;
    logic f;
    logic o;
    f = !r.fcs_ok || r.rx_er_seen;
    o = r.data_bytes[0];
    x.valid = 1'b1;
    x.status = {f && (r.mii_mode ? r.nibble_odd : r.bit_residual != 3'h0), r.dest_bcast, f, o,
      r.data_bytes > 16'h05EE, r.data_bytes < 16'h0040, 4'h0, r.dest_crc[31:26]};
    x.count = r.data_bytes + (o ? 16'h0005 : 16'h0006);
    x.ctrl = {2'h1, o, 5'h00};
    x.accept = r.dest_group && tbl[r.dest_crc[31:26]];
    return x;
  endfunction : exp_rx
  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (4000) @(posedge clk);
    failures++;
    summarize();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    check("reset outputs", {bank, extn, tdone, res.valid}, 6'h04);
    acc(1'b0, 4'hC, 4'hC, 32'h0);
    check("bank select read", {acked, rd[31:24], rd[18:16]}, {1'b1, 8'h5A, 3'h0});
    @(posedge clk) {ios, eeb, eel} <= {3'h5, 9'h0A3, 1'b1};
    @(posedge clk) eel <= 1'b0;
    acc(1'b0, 4'hC, 4'hC, 32'h0);
    check("old base ack", acked, 1'b0);
    base = {9'h0A3, 3'h5};
    acc(1'b1, 4'hE, 4'h4, 32'h0003_0000);
    acc(1'b0, 4'h8, 4'hC, 32'h0);
    check("revision", {acked, rd[31:16]}, {1'b1, 16'h0001});
    for (int b = 0; b < 8; b++)
    begin
      acc(1'b1, 4'hC, b[0] ? 4'h4 : 4'hF, {13'h0, b[2:0], 16'hFFFF});
      check("bank", {acked, bank}, {1'b1, b[2:0]});
      acc(1'b0, 4'hC, 4'h3, 32'h0);
      check("offset c", {extn, rd[15:0]}, 17'h10000);
      acc(1'b0, 4'h0, 4'h1, 32'h0);
      check("ext select", extn, b != 7);
    end
    $display("test window done");
    acc(1'b1, 4'hE, 4'h4, 32'h0003_0000);
    tbl = {$random(seed), $random(seed)};
    acc(1'b1, 4'h0, 4'hF, tbl[31:0]);
    acc(1'b1, 4'h4, 4'hF, tbl[63:32]);
    acc(1'b0, 4'h4, 4'h2, 32'h0);
    check("hash byte lane", rd[15:8], tbl[47:40]);
    for (int i = 0; i < 40; i++)
    begin
      rnd = {$random(seed), $random(seed)};
      rr = rnd[57:0];
      rr.done = 1'b1;
      rr.data_bytes = i < 4 ? 16'h003F + (i[1] ? 16'h05AF : 16'h0000) + {15'h0, i[0]} : 16'h0001 + (rnd[15:0] & 16'h07FF);
      @(posedge clk) rep <= rr;
      @(posedge clk) rep <= {1'b0, ~rr[56:0]};
      @(posedge clk) e = exp_rx(rr);
      check("rx status", res.status, e.status);
      check("rx result", {res.valid, res.count, res.ctrl, res.accept}, {e.valid, e.count, e.ctrl, e.accept});
    end
    $display("test receive done");
    for (int s = 0; s < 2; s++)
    begin
      acc(1'b1, 4'hE, 4'h4, 32'h0);
      acc(1'b1, 4'h0, 4'h2, {23'h0, s[0], 8'h00});
      for (int i = 0; i < 12; i++)
      begin
        // corners: too short, empty, largest legal area, one word over; odd count bit must be ignored
        c = i < 4 ? (i[1] ? 16'h0801 : 16'h0004) + {14'h0000, i[0], 1'b0} : 16'($random(seed)) & 16'h0FFF;
        ct = 8'($random(seed));
        @(posedge clk) {txv, txc, txct} <= {1'b1, c, ct};
        @(posedge clk) {txv, txc, txct} <= {1'b0, ~c, ~ct};
        @(posedge clk) check("tx descriptor", {tdone, tlen, fcs, lerr}, exp_tx(c, ct, s[0]));
      end
    end
    $display("test transmit done");
    summarize();
  end
endmodule : bpl_io_window_tb
